// ---- verilog/dsc_regs_map.vh ----
// register offsets, field positions, reset values and timing for the span config bank
`ifndef DSC_REGS_MAP_VH
`define DSC_REGS_MAP_VH

`define DSC_ADDR_W 7
`define DSC_OFF_ALARM_MASK 7'h16
`define DSC_OFF_ERROR_FLAGS 7'h17
`define DSC_OFF_POWER_DOWN 7'h18
`define DSC_OFF_SPAN_PRESET 7'h19
`define DSC_OFF_OFFSET_LOW 7'h1B
`define DSC_OFF_CUSTOM_GAIN 7'h1C

`define DSC_RST_ERROR_FLAGS 8'h01
`define DSC_RST_ALARM_MASK 8'h00
`define DSC_RST_POWER_DOWN 8'h00
`define DSC_RST_SPAN_PRESET 8'h00
`define DSC_RST_OFFSET_LOW 8'h00
`define DSC_RST_CUSTOM_GAIN 8'h00

`define DSC_ERR_RESET_DONE 0
`define DSC_ERR_MEM_CHECK 4
`define DSC_ERR_STREAM_OVR 5
`define DSC_ERR_REF_LOW 6
`define DSC_ERR_IMPL_MASK 8'h71
`define DSC_MASK_IMPL 8'h7F

`define DSC_PD_SLEEP_BIT 4
`define DSC_PD_IMPL_MASK 8'h10
`define DSC_SPAN_IMPL_MASK 8'h0F
`define DSC_GAIN_IMPL_MASK 8'hFD

`define DSC_GAIN_CUSTOM_BIT 7
`define DSC_GAIN_SINK_HI 6
`define DSC_GAIN_SINK_LO 5
`define DSC_GAIN_SRC_HI 4
`define DSC_GAIN_SRC_LO 3
`define DSC_GAIN_SIGN_BIT 2
`define DSC_GAIN_OFS8_BIT 0

`define DSC_SPAN_0_2V5 4'h0
`define DSC_SPAN_0_5V 4'h1
`define DSC_SPAN_0_10V 4'h2
`define DSC_SPAN_PM5V 4'h3
`define DSC_SPAN_PM10V 4'h4

// initialization time after reset, in ns
`define DSC_INIT_TIME_NS 100
`define DSC_CLK_PERIOD_NS 5

`endif

// ---- verilog/dsc_sync3.v ----
// three-stage synchroniser with agreement-based change detection
`timescale 1ns/100ps
`default_nettype none
module dsc_sync3 #(
    parameter WIDTH = 1
) (
    input wire mclk,
    input wire reset,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_ff;
    reg [WIDTH-1:0] stage2_ff;
    reg [WIDTH-1:0] stage3_ff;
    wire [WIDTH-1:0] nxt_sync;
    genvar i;

    always @(posedge mclk) begin
        if (reset) begin
            stage1_ff <= {WIDTH{1'b0}};
            stage2_ff <= {WIDTH{1'b0}};
            stage3_ff <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            sync_out <= nxt_sync;
        end
    end

    // output follows only once the second and third stages agree
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            assign nxt_sync[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i] : sync_out[i];
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verilog/dsc_span_regs.v ----
// error flags, power-down, span preset and custom span registers of the converter
`include "dsc_regs_map.vh"
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - error flags stay set until host writes one to the bit; zero leaves them
// - after reset initialization completes, reset-done flag sets so flags read 0x01
// - reset-done flag drives alarm active regardless of mask
// - reference-low indication sets flag bit 6
// - dual-mode streaming past end of converter map sets flag bit 5
// - background checksum corruption sets flag bit 4
// - power-down bit 4 puts the converter to sleep; reset value zero
// - span preset bits 3:0 select one of five output spans
// - custom offset only takes effect while custom span enable is set
// - gain bit 7 chooses preset span or custom offset and gain
// - gain bits 6:5 scale sink array codes by 1, 1/2, 1/4, 1/8
// - gain bits 4:3 scale source array codes with the same encoding
// - gain bit 2 gives offset sign, one is negative
// - offset is 9 bits: low byte register plus gain bit 0
// - each set alarm mask bit except bit 0 (reset-done) stops its error from asserting alarm
module dsc_span_regs #(
    parameter INIT_TIME_NS = `DSC_INIT_TIME_NS
) (
    input wire mclk,
    input wire reset,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [`DSC_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output wire reg_rvalid,
    input wire ref_low_pin,
    input wire stream_overrun_flag,
    input wire mem_check_error,
    output wire alarm_n,
    output reg converter_sleep,
    output reg [3:0] span_preset_select,
    output reg custom_span_enable,
    output reg [1:0] sink_array_scale,
    output reg [1:0] source_array_scale,
    output reg offset_sign,
    output reg [8:0] offset_applied,
    output reg [3:0] sink_array_shift,
    output reg [3:0] source_array_shift,
    output wire init_done
);
    localparam integer INIT_CYCLES = (INIT_TIME_NS + `DSC_CLK_PERIOD_NS - 1) / `DSC_CLK_PERIOD_NS;
    localparam integer INIT_LIM = (INIT_CYCLES < 1) ? 1 : INIT_CYCLES;
    localparam [7:0] INIT_LAST = INIT_LIM[7:0];

    localparam ST_INIT = 1'b0;
    localparam ST_RUN = 1'b1;

    reg state_ff;
    reg nxt_state;
    reg [7:0] init_cnt_ff;
    reg [7:0] nxt_init_cnt;
    reg [7:0] err_flags_ff;
    reg [7:0] nxt_err_flags;
    reg [7:0] alarm_mask_ff;
    reg [7:0] power_down_ff;
    reg [7:0] span_preset_ff;
    reg [7:0] offset_low_ff;
    reg [7:0] custom_gain_ff;
    reg rvalid_ff;
    reg [7:0] set_ev;
    reg [7:0] clr_ev;
    reg [7:0] rd_mux;
    wire ref_low_sync;
    // level sensitive: the flag re-arms while the reference stays low
    wire ref_low_set;
    wire alarm_active;

    // maps a two-bit scale code to a right shift count of the array codes
    function [3:0] scale_to_shift;
        input [1:0] code;
        begin
            case (code)
                2'b00: scale_to_shift = 4'h0;
                2'b01: scale_to_shift = 4'h1;
                2'b10: scale_to_shift = 4'h2;
                2'b11: scale_to_shift = 4'h3;
                default: scale_to_shift = 4'h0;
            endcase
        end
    endfunction

    function is_write_to;
        input we;
        input [`DSC_ADDR_W-1:0] addr;
        input [`DSC_ADDR_W-1:0] target;
        begin
            is_write_to = we && (addr == target);
        end
    endfunction

    dsc_sync3 #(
        .WIDTH(1)
    ) u_ref_sync (
        .mclk(mclk),
        .reset(reset),
        .async_in(ref_low_pin),
        .sync_out(ref_low_sync)
    );

    // initialization sequencer after reset
    always @* begin
        nxt_state = state_ff;
        nxt_init_cnt = init_cnt_ff;
        case (state_ff)
            ST_INIT: begin
                if (init_cnt_ff == INIT_LAST - 8'h01) begin
                    nxt_state = ST_RUN;
                end else begin
                    nxt_init_cnt = init_cnt_ff + 8'h01;
                end
            end
            ST_RUN: begin
                nxt_init_cnt = init_cnt_ff;
            end
            default: begin
                nxt_state = ST_INIT;
                nxt_init_cnt = 8'h00;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (reset) begin
            state_ff <= ST_INIT;
            init_cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            init_cnt_ff <= nxt_init_cnt;
        end
    end

    assign init_done = (state_ff == ST_RUN);
    assign ref_low_set = ref_low_sync;

    // sticky flag update, a set in the same cycle as a clear wins
    always @* begin
        set_ev = 8'h00;
        set_ev[`DSC_ERR_RESET_DONE] = (state_ff == ST_INIT) && (nxt_state == ST_RUN);
        set_ev[`DSC_ERR_REF_LOW] = ref_low_set;
        set_ev[`DSC_ERR_STREAM_OVR] = stream_overrun_flag;
        set_ev[`DSC_ERR_MEM_CHECK] = mem_check_error;
        clr_ev = 8'h00;
        if (is_write_to(reg_wr_en, reg_addr, `DSC_OFF_ERROR_FLAGS)) begin
            clr_ev = reg_wdata & `DSC_ERR_IMPL_MASK;
        end
        nxt_err_flags = ((err_flags_ff & ~clr_ev) | set_ev) & `DSC_ERR_IMPL_MASK;
    end

    always @(posedge mclk) begin
        if (reset) begin
            err_flags_ff <= 8'h00;
        end else begin
            err_flags_ff <= nxt_err_flags;
        end
    end

    // read-write configuration registers
    always @(posedge mclk) begin
        if (reset) begin
            alarm_mask_ff <= `DSC_RST_ALARM_MASK;
            power_down_ff <= `DSC_RST_POWER_DOWN;
            span_preset_ff <= `DSC_RST_SPAN_PRESET;
            offset_low_ff <= `DSC_RST_OFFSET_LOW;
            custom_gain_ff <= `DSC_RST_CUSTOM_GAIN;
        end else begin
            if (is_write_to(reg_wr_en, reg_addr, `DSC_OFF_ALARM_MASK)) begin
                alarm_mask_ff <= reg_wdata & `DSC_MASK_IMPL;
            end
            if (is_write_to(reg_wr_en, reg_addr, `DSC_OFF_POWER_DOWN)) begin
                power_down_ff <= reg_wdata & `DSC_PD_IMPL_MASK;
            end
            if (is_write_to(reg_wr_en, reg_addr, `DSC_OFF_SPAN_PRESET)) begin
                span_preset_ff <= reg_wdata & `DSC_SPAN_IMPL_MASK;
            end
            if (is_write_to(reg_wr_en, reg_addr, `DSC_OFF_OFFSET_LOW)) begin
                offset_low_ff <= reg_wdata;
            end
            if (is_write_to(reg_wr_en, reg_addr, `DSC_OFF_CUSTOM_GAIN)) begin
                custom_gain_ff <= reg_wdata & `DSC_GAIN_IMPL_MASK;
            end
        end
    end

    // read data mux, unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `DSC_OFF_ALARM_MASK: rd_mux = alarm_mask_ff;
            `DSC_OFF_ERROR_FLAGS: rd_mux = err_flags_ff;
            `DSC_OFF_POWER_DOWN: rd_mux = power_down_ff;
            `DSC_OFF_SPAN_PRESET: rd_mux = span_preset_ff;
            `DSC_OFF_OFFSET_LOW: rd_mux = offset_low_ff;
            `DSC_OFF_CUSTOM_GAIN: rd_mux = custom_gain_ff;
            default: rd_mux = 8'h00;
        endcase
    end

    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    assign reg_rvalid = rvalid_ff;

    // alarm: unmasked sticky flags, reset-done cannot be masked
    assign alarm_active = err_flags_ff[`DSC_ERR_RESET_DONE] |
        (|(err_flags_ff & ~alarm_mask_ff & `DSC_ERR_IMPL_MASK & 8'hFE));
    assign alarm_n = ~alarm_active;

    // decoded analog controls
    always @(posedge mclk) begin
        if (reset) begin
            converter_sleep <= 1'b0;
            span_preset_select <= 4'h0;
            custom_span_enable <= 1'b0;
            sink_array_scale <= 2'b00;
            source_array_scale <= 2'b00;
            offset_sign <= 1'b0;
            offset_applied <= 9'h000;
            sink_array_shift <= 4'h0;
            source_array_shift <= 4'h0;
        end else begin
            converter_sleep <= power_down_ff[`DSC_PD_SLEEP_BIT];
            span_preset_select <= span_preset_ff[3:0];
            custom_span_enable <= custom_gain_ff[`DSC_GAIN_CUSTOM_BIT];
            sink_array_scale <= custom_gain_ff[`DSC_GAIN_SINK_HI:`DSC_GAIN_SINK_LO];
            source_array_scale <= custom_gain_ff[`DSC_GAIN_SRC_HI:`DSC_GAIN_SRC_LO];
            offset_sign <= custom_gain_ff[`DSC_GAIN_SIGN_BIT];
            if (custom_gain_ff[`DSC_GAIN_CUSTOM_BIT]) begin
                // custom path: offset and gain scaling take effect
                offset_applied <= {custom_gain_ff[`DSC_GAIN_OFS8_BIT], offset_low_ff};
                sink_array_shift <= scale_to_shift(
                    custom_gain_ff[`DSC_GAIN_SINK_HI:`DSC_GAIN_SINK_LO]);
                source_array_shift <= scale_to_shift(
                    custom_gain_ff[`DSC_GAIN_SRC_HI:`DSC_GAIN_SRC_LO]);
            end else begin
                offset_applied <= 9'h000;
                sink_array_shift <= 4'h0;
                source_array_shift <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/dsc_span_regs_assertions.sv ----
// checker for the span config register bank
`timescale 1ns/100ps
`default_nettype none
module dsc_span_regs_chk #(
    parameter INIT_TIME_NS = 100
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic stream_overrun_flag,
    input wire logic mem_check_error,
    input wire logic alarm_n,
    input wire logic converter_sleep,
    input wire logic [3:0] span_preset_select,
    input wire logic [8:0] offset_applied,
    input wire logic [3:0] sink_array_shift,
    input wire logic init_done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_sleep;
        reg_wr_en && reg_addr == 7'h18 |-> ##2 converter_sleep == $past(reg_wdata[4], 2);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep mismatch");
    property p_span;
        reg_wr_en && reg_addr == 7'h19 |-> ##2 span_preset_select == $past(reg_wdata[3:0], 2);
    endproperty
    a_span: assert property (p_span) else $error("span mismatch");
    property p_unmapped;
        reg_rd_en && reg_addr == 7'h20 |=> reg_rvalid && reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_reserved;
        reg_rd_en && reg_addr == 7'h17 |=> reg_rdata[3:1] == 3'h0 && !reg_rdata[7];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    property p_mem;
        reg_rd_en && reg_addr == 7'h17 && $past(mem_check_error) |=> reg_rdata[4];
    endproperty
    a_mem: assert property (p_mem) else $error("checksum flag lost");
    property p_stream;
        reg_rd_en && reg_addr == 7'h17 && $past(stream_overrun_flag) |=> reg_rdata[5];
    endproperty
    a_stream: assert property (p_stream) else $error("overrun flag lost");
    property p_alarm;
        reg_rvalid && reg_rdata[0] && $past(reg_addr) == 7'h17 && !$past(reg_wr_en) |-> !alarm_n;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm not active");
    property p_custom_off;
        reg_wr_en && reg_addr == 7'h1C && !reg_wdata[7]
            |-> ##2 offset_applied == 9'h000 && sink_array_shift == 4'h0;
    endproperty
    a_custom_off: assert property (p_custom_off) else $error("custom span leak");
    property p_init;
        $fell(reset) |-> ##[1:40] init_done;
    endproperty
    a_init: assert property (p_init) else $error("init not done");
    c_clear: cover property (reg_wr_en && reg_addr == 7'h17);
    c_init: cover property ($rose(init_done));
    c_ovr: cover property (stream_overrun_flag);
endmodule
bind dsc_span_regs dsc_span_regs_chk #(.INIT_TIME_NS(INIT_TIME_NS)) chk_u (
    .mclk, .reset, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .stream_overrun_flag, .mem_check_error, .alarm_n, .converter_sleep, .span_preset_select,
    .offset_applied, .sink_array_shift, .init_done
);
`default_nettype wire

// ---- testbench/dsc_host_model.sv ----
// host-side register access model for the span config bank
`timescale 1ns/100ps
`default_nettype none
module dsc_host_model (
    input wire logic mclk,
    output logic wr_en,
    output logic rd_en,
    output logic [6:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 7'h00;
        wdata = 8'h00;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge mclk);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge mclk);
        addr = a;
        rd_en = 1'b1;
        @(negedge mclk);
        rd_en = 1'b0;
        d = rvalid ? rdata : 8'hXX;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the span config register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic ref_low = 1'b0, ovr = 1'b0, mem_err = 1'b0;
    logic wr_en, rd_en, rvalid, alarm_n, sleep, cust, sign, init_done;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, rd_v;
    logic [3:0] span, sink_sh, src_sh;
    logic [1:0] sink_sc, src_sc;
    logic [8:0] ofs;
    int error_cnt = 0;
    int n_checks = 0;
    always #2.5 mclk = ~mclk;
    dsc_span_regs #(.INIT_TIME_NS(25)) dut_u (.mclk(mclk), .reset(reset), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .ref_low_pin(ref_low), .stream_overrun_flag(ovr),
        .mem_check_error(mem_err), .alarm_n(alarm_n), .converter_sleep(sleep),
        .span_preset_select(span), .custom_span_enable(cust), .sink_array_scale(sink_sc),
        .source_array_scale(src_sc), .offset_sign(sign), .offset_applied(ofs),
        .sink_array_shift(sink_sh), .source_array_shift(src_sh), .init_done(init_done));
    dsc_host_model host_u (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd_chk(input logic [6:0] a, input logic [7:0] e);
        host_u.rd(a, rd_v);
        chk({8'h00, rd_v}, {8'h00, e});
    endtask
    task t_init;
        begin
            for (int i = 0; i < 40 && init_done !== 1'b1; i++) @(negedge mclk);
            rd_chk(7'h17, 8'h01);
            chk(alarm_n, 1'b0);
            host_u.wr(7'h16, 8'hFF);
            rd_chk(7'h16, 8'h7F);
            chk(alarm_n, 1'b0);
            host_u.wr(7'h17, 8'h00);
            rd_chk(7'h17, 8'h01);
            host_u.wr(7'h17, 8'h01);
            rd_chk(7'h17, 8'h00);
            chk(alarm_n, 1'b1);
            rd_chk(7'h18, 8'h00);
            rd_chk(7'h19, 8'h00);
            rd_chk(7'h1B, 8'h00);
            rd_chk(7'h1C, 8'h00);
        end
    endtask
    // clear in the same cycle as a set, then a second reset in mid-run
    task t_rerst;
        begin
            mem_err = 1'b1;
            host_u.wr(7'h17, 8'h10);
            mem_err = 1'b0;
            rd_chk(7'h17, 8'h10);
            @(negedge mclk);
            reset = 1'b1;
            repeat (3) @(negedge mclk);
            reset = 1'b0;
            chk({init_done, alarm_n, sleep, ofs}, 12'h400);
            for (int i = 0; i < 40 && init_done !== 1'b1; i++) @(negedge mclk);
            rd_chk(7'h17, 8'h01);
            chk(alarm_n, 1'b0);
            rd_chk(7'h16, 8'h00);
            rd_chk(7'h19, 8'h00);
            rd_chk(7'h1C, 8'h00);
            host_u.wr(7'h17, 8'h01);
            chk(alarm_n, 1'b1);
            rd_chk(7'h17, 8'h00);
        end
    endtask
    task t_flags;
        for (int b = 4; b < 7; b++) begin
            mem_err = (b == 4);
            ovr = (b == 5);
            ref_low = (b == 6);
            repeat (8) @(negedge mclk);
            rd_chk(7'h17, 8'h01 << b);
            mem_err = 1'b0;
            ovr = 1'b0;
            ref_low = 1'b0;
            repeat (8) @(negedge mclk);
            chk(alarm_n, 1'b1);
            host_u.wr(7'h16, 8'h00);
            chk(alarm_n, 1'b0);
            host_u.wr(7'h17, 8'h01 << b);
            rd_chk(7'h17, 8'h00);
            host_u.wr(7'h16, 8'h7F);
        end
    endtask
    task t_cfg;
        host_u.wr(7'h18, 8'hFF);
        @(negedge mclk);
        chk(sleep, 1'b1);
        rd_chk(7'h18, 8'h10);
        for (int c = 0; c < 5; c++) begin
            host_u.wr(7'h19, 8'(c));
            @(negedge mclk);
            chk(span, 4'(c));
        end
        host_u.wr(7'h1B, 8'hAB);
        host_u.wr(7'h1C, 8'h7D);
        @(negedge mclk);
        chk({cust, ofs, sink_sh}, 14'h0000);
        host_u.wr(7'h1C, 8'hEF);
        @(negedge mclk);
        chk({cust, sink_sc, src_sc, sign}, 6'h3B);
        chk(ofs, 9'h1AB);
        chk({sink_sh, src_sh}, 8'h31);
        rd_chk(7'h1C, 8'hED);
        rd_chk(7'h20, 8'h00);
    endtask
    task close_out;
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        t_init;
        t_flags;
        t_cfg;
        t_rerst;
        close_out;
    end
    initial begin
        #20000;
        error_cnt++;
        close_out;
    end
endmodule
`default_nettype wire
